// *** src/vsic_map.vh ***
`ifndef VSIC_MAP_VH
`define VSIC_MAP_VH
// register indices; byte address is four times the index
`define VSIC_IDX_STD_SEL 12'h020
`define VSIC_IDX_INSEL 12'h021
`define VSIC_IDX_START_POS 12'h022
`define VSIC_IDX_LC_DELAY 12'h023
`define VSIC_IDX_HELPER_DLY 12'h029
`define VSIC_IDX_ASR_MASK 12'h148
`define VSIC_IDX_ASR_STATE 12'h14e
`define VSIC_IDX_IRQ_STAT 12'h150
`define VSIC_IDX_IRQ_MASK 12'h151
// reset values
`define VSIC_RST_STD_SEL 12'h000
`define VSIC_RST_INSEL 12'h644
`define VSIC_RST_ZERO 12'h000
// standard-select fields
`define VSIC_STD_LO 0
`define VSIC_STD_HI 2
`define VSIC_PALPLUS_BIT 4
`define VSIC_COMB_BIT 5
`define VSIC_SEPARATE_BIT 6
`define VSIC_OPT_NO_HPLL 7
`define VSIC_OPT_NO_VERT 8
`define VSIC_OPT_NO_ACC 9
`define VSIC_OPT_COMB_ONLY 10
`define VSIC_DONE_BIT 11
// input-select fields
`define VSIC_IFC_LO 3
`define VSIC_IFC_HI 4
`define VSIC_TRAP_BIT 7
`define VSIC_SMOOTH_BIT 8
`define VSIC_HLOCK_LO 9
`define VSIC_HLOCK_HI 10
// standard codes
`define VSIC_STD_SECAM 3'h2
// standards by field rate (bit per standard)
`define VSIC_STDS_50HZ 7'h25
`define VSIC_STDS_60HZ 7'h5a
// recognition state codes
`define VSIC_ASR_OK 4'h0
`define VSIC_ASR_VWIN 4'h1
`define VSIC_ASR_DISABLED 4'h2
`define VSIC_ASR_BUSY 4'h4
`define VSIC_ASR_FAILED 4'h8
// interrupt status bits
`define VSIC_IRQ_STD_DONE 0
`define VSIC_IRQ_INSEL_DONE 1
`define VSIC_IRQ_ASR_DONE 2
// setup timing
`define VSIC_CLK_PERIOD_NS 8
`define VSIC_PHASE_TIME_NS 32
`define VSIC_PHASE_CYCLES (`VSIC_PHASE_TIME_NS / `VSIC_CLK_PERIOD_NS)
`endif

// *** src/vsic_video_standard_input_control.v ***
// Register access over APB was decided locally.
`timescale 1ns/1ps
// Operation
// - separate-input and comb bits pick composite, comb, separate, or composite without notch
// - option bits 7..10 skip hpll, vertical, colour gain setup, or do comb only
// - standard-select done bit set by processor when switch finishes; software writes zero
// - any input-select write starts initialisation of current standard, skipping the phases that the standard-select option bits suppress
// - recognition only considers standards whose mask bit is one
// - recognition state: vwin error, disabled, search active, failed in bits 0..3
// - codes 0001 vwin, 0010 disabled, x1x0 running, 1x00 failed
// - if compensation off, 6 dB, 12 dB; code 11 only valid with secam
// - input-select holds secam trap mode, luma smoothing and horizontal lock speed
// - input-select done bit set on completion; software writes zero
// - start position takes effect on next standard-select or scaler mode write
// - luma delay in bits 11:6, range +1 to -7, low bits zero, applied on standard write
// - helper delay signed 12 bits, used only in pal plus mode
// - standard-select change reloads every standard-dependent register
`include "vsic_map.vh"

module vsic_video_standard_input_control (
  input wire core_clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire irq,
  input wire scaler_mode_written,
  input wire asr_start,
  input wire asr_vwin_error,
  input wire asr_field_60hz,
  input wire asr_found_valid,
  input wire asr_found_ok,
  input wire [2:0] asr_found_std,
  output reg [2:0] active_standard,
  output reg [1:0] input_mode,
  output reg comb_enable,
  output reg separate_luma_chroma_input,
  output reg luma_notch_enable,
  output reg [1:0] if_compensation,
  output reg secam_trap_mode,
  output reg luma_smoothing_enable,
  output reg [1:0] horizontal_lock_speed,
  output reg [11:0] active_video_start,
  output reg [5:0] luma_chroma_delay,
  output reg [11:0] helper_line_delay,
  output reg standard_reload,
  output reg [2:0] setup_phase,
  output reg setup_busy
);

  localparam S_IDLE = 3'd0;
  localparam S_HPLL = 3'd1;
  localparam S_VERT = 3'd2;
  localparam S_ACC = 3'd3;
  localparam S_COMB = 3'd4;

  localparam R_IDLE = 1'b0;
  localparam R_SEARCH = 1'b1;

  localparam integer PHASE_CNT_FULL = `VSIC_PHASE_CYCLES;
  localparam [7:0] PHASE_CNT = PHASE_CNT_FULL[7:0];

  reg [11:0] std_sel_reg;
  reg [11:0] insel_reg;
  reg [11:0] start_pos_reg;
  reg [11:0] lc_delay_reg;
  reg [11:0] helper_dly_reg;
  reg [6:0] asr_mask_reg;
  reg [3:0] asr_state_reg;
  reg [2:0] irq_stat_reg;
  reg [2:0] irq_mask_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] cnt_reg;
  reg op_insel_reg;
  reg asr_fsm_reg;
  reg [31:0] rdata;
  reg hit;
  reg [2:0] irq_set;

  // index compare shared by every write strobe
  function idx_is;
    input [11:0] a;
    input [11:0] want;
    begin
      idx_is = (a == want);
    end
  endfunction

  // byte lanes are ignored; every register is one aligned word
  wire [11:0] idx = {2'b00, paddr[11:2]};
  wire wr_en = psel & penable & pwrite;
  wire std_wr = wr_en & idx_is(idx, `VSIC_IDX_STD_SEL);
  wire insel_wr = wr_en & idx_is(idx, `VSIC_IDX_INSEL);
  wire start_pos_wr = wr_en & idx_is(idx, `VSIC_IDX_START_POS);
  wire lc_delay_wr = wr_en & idx_is(idx, `VSIC_IDX_LC_DELAY);
  wire helper_wr = wr_en & idx_is(idx, `VSIC_IDX_HELPER_DLY);
  wire asr_mask_wr = wr_en & idx_is(idx, `VSIC_IDX_ASR_MASK);
  wire irq_mask_wr = wr_en & idx_is(idx, `VSIC_IDX_IRQ_MASK);
  wire irq_stat_wr = wr_en & idx_is(idx, `VSIC_IDX_IRQ_STAT);
  wire start_init = std_wr | insel_wr;
  // a phase ends when its countdown reaches zero
  wire phase_end = (state_reg != S_IDLE) & (cnt_reg == 8'd0);
  wire init_done = (state_reg == S_COMB) & phase_end;
  wire [6:0] rate_set = asr_field_60hz ? `VSIC_STDS_60HZ : `VSIC_STDS_50HZ;
  // a found code of seven has no mask bit, so the padded zero makes it fail
  wire [7:0] asr_mask_ext = {1'b0, asr_mask_reg};
  wire [2:0] irq_stat_next;

  // next setup phase, skipping those the options suppress
  function [2:0] next_phase;
    input [2:0] cur;
    input [11:0] opt;
    begin
      case (cur)
        S_IDLE: begin
          if (opt[`VSIC_OPT_COMB_ONLY])
            next_phase = S_COMB;
          else if (!opt[`VSIC_OPT_NO_HPLL])
            next_phase = S_HPLL;
          else if (!opt[`VSIC_OPT_NO_VERT])
            next_phase = S_VERT;
          else if (!opt[`VSIC_OPT_NO_ACC])
            next_phase = S_ACC;
          else
            next_phase = S_COMB;
        end
        S_HPLL: begin
          if (!opt[`VSIC_OPT_NO_VERT])
            next_phase = S_VERT;
          else if (!opt[`VSIC_OPT_NO_ACC])
            next_phase = S_ACC;
          else
            next_phase = S_COMB;
        end
        S_VERT: next_phase = opt[`VSIC_OPT_NO_ACC] ? S_COMB : S_ACC;
        S_ACC: next_phase = S_COMB;
        default: next_phase = S_IDLE;
      endcase
    end
  endfunction

  // clamp a 6-bit two's complement delay into +1 .. -7
  function [5:0] clamp_delay;
    input [5:0] d;
    begin
      if (!d[5] && d > 6'h01)
        clamp_delay = 6'h01;
      else if (d[5] && d < 6'h39)
        clamp_delay = 6'h39;
      else
        clamp_delay = d;
    end
  endfunction

  // insel-triggered runs reuse the option bits held in standard select
  always @* begin
    state_next = state_reg;
    if (std_wr)
      state_next = next_phase(S_IDLE, pwdata[11:0]);
    else if (insel_wr)
      state_next = next_phase(S_IDLE, std_sel_reg);
    else if (phase_end)
      state_next = next_phase(state_reg, std_sel_reg);
  end

  always @* begin
    irq_set = 3'h0;
    irq_set[`VSIC_IRQ_STD_DONE] = init_done & ~op_insel_reg;
    irq_set[`VSIC_IRQ_INSEL_DONE] = init_done & op_insel_reg;
    irq_set[`VSIC_IRQ_ASR_DONE] = (asr_fsm_reg == R_SEARCH) & asr_found_valid;
  end

  // per-bit sticky status; a set in the same cycle beats a write-one clear
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_irq_stat
      assign irq_stat_next[g] = irq_set[g] | (irq_stat_reg[g] & ~(irq_stat_wr & pwdata[g]));
    end
  endgenerate

  // setup sequencer; a new command restarts it from the first phase
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= S_IDLE;
      cnt_reg <= 8'h00;
      op_insel_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (start_init || phase_end)
        cnt_reg <= PHASE_CNT - 8'd1;
      else if (state_reg != S_IDLE)
        cnt_reg <= cnt_reg - 8'd1;
      // which done bit to set depends on the command that started the run
      if (start_init)
        op_insel_reg <= insel_wr;
    end
  end

  // register file; hardware set of a done bit wins over a software clear
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      std_sel_reg <= `VSIC_RST_STD_SEL;
      insel_reg <= `VSIC_RST_INSEL;
      start_pos_reg <= `VSIC_RST_ZERO;
      lc_delay_reg <= `VSIC_RST_ZERO;
      helper_dly_reg <= `VSIC_RST_ZERO;
      asr_mask_reg <= 7'h00;
      irq_mask_reg <= 3'h0;
      irq_stat_reg <= 3'h0;
    end else begin
      if (std_wr) begin
        std_sel_reg[10:0] <= pwdata[10:0];
        if (!pwdata[`VSIC_DONE_BIT])
          std_sel_reg[`VSIC_DONE_BIT] <= 1'b0;
      end
      if (init_done && !op_insel_reg)
        std_sel_reg[`VSIC_DONE_BIT] <= 1'b1;
      if (insel_wr) begin
        insel_reg[10:0] <= pwdata[10:0];
        if (!pwdata[`VSIC_DONE_BIT])
          insel_reg[`VSIC_DONE_BIT] <= 1'b0;
      end
      if (init_done && op_insel_reg)
        insel_reg[`VSIC_DONE_BIT] <= 1'b1;
      if (start_pos_wr)
        start_pos_reg <= pwdata[11:0];
      // low six bits always read back zero
      if (lc_delay_wr)
        lc_delay_reg <= {clamp_delay(pwdata[11:6]), 6'h00};
      if (helper_wr)
        helper_dly_reg <= pwdata[11:0];
      if (asr_mask_wr)
        asr_mask_reg <= pwdata[6:0];
      if (irq_mask_wr)
        irq_mask_reg <= pwdata[2:0];
      irq_stat_reg <= irq_stat_next;
    end
  end

  // applied settings; latched values only move on their trigger writes
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      active_standard <= 3'h0;
      input_mode <= 2'h0;
      comb_enable <= 1'b0;
      separate_luma_chroma_input <= 1'b0;
      luma_notch_enable <= 1'b1;
      if_compensation <= 2'h0;
      secam_trap_mode <= 1'b0;
      luma_smoothing_enable <= 1'b0;
      horizontal_lock_speed <= 2'h3;
      active_video_start <= 12'h000;
      luma_chroma_delay <= 6'h00;
      helper_line_delay <= 12'h000;
      standard_reload <= 1'b0;
      setup_phase <= S_IDLE;
      setup_busy <= 1'b0;
    end else begin
      standard_reload <= std_wr;
      setup_phase <= state_next;
      setup_busy <= state_next != S_IDLE;
      active_standard <= std_sel_reg[`VSIC_STD_HI:`VSIC_STD_LO];
      input_mode <= {std_sel_reg[`VSIC_SEPARATE_BIT], std_sel_reg[`VSIC_COMB_BIT]};
      case ({std_sel_reg[`VSIC_SEPARATE_BIT], std_sel_reg[`VSIC_COMB_BIT]})
        2'b00: begin
          comb_enable <= 1'b0;
          separate_luma_chroma_input <= 1'b0;
          luma_notch_enable <= 1'b1;
        end
        2'b01: begin
          comb_enable <= 1'b1;
          separate_luma_chroma_input <= 1'b0;
          luma_notch_enable <= 1'b0;
        end
        2'b10: begin
          comb_enable <= 1'b0;
          separate_luma_chroma_input <= 1'b1;
          luma_notch_enable <= 1'b0;
        end
        default: begin
          comb_enable <= 1'b0;
          separate_luma_chroma_input <= 1'b0;
          luma_notch_enable <= 1'b0;
        end
      endcase
      // code 11 is meaningless outside secam, so it falls back to off
      if (insel_reg[`VSIC_IFC_HI:`VSIC_IFC_LO] == 2'h3 &&
          std_sel_reg[`VSIC_STD_HI:`VSIC_STD_LO] != `VSIC_STD_SECAM)
        if_compensation <= 2'h0;
      else
        if_compensation <= insel_reg[`VSIC_IFC_HI:`VSIC_IFC_LO];
      secam_trap_mode <= insel_reg[`VSIC_TRAP_BIT];
      luma_smoothing_enable <= insel_reg[`VSIC_SMOOTH_BIT];
      // code 00 keeps the previous speed rather than forcing one
      if (insel_reg[`VSIC_HLOCK_HI:`VSIC_HLOCK_LO] != 2'h0)
        horizontal_lock_speed <= insel_reg[`VSIC_HLOCK_HI:`VSIC_HLOCK_LO];
      // start position is double-buffered; only a trigger write moves it
      if (std_wr || scaler_mode_written)
        active_video_start <= start_pos_reg;
      if (std_wr)
        luma_chroma_delay <= lc_delay_reg[11:6];
      // helper delay only means something in pal plus; zero otherwise
      if (std_sel_reg[`VSIC_PALPLUS_BIT])
        helper_line_delay <= helper_dly_reg;
      else
        helper_line_delay <= 12'h000;
    end
  end

  // automatic standard recognition
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      asr_fsm_reg <= R_IDLE;
      asr_state_reg <= `VSIC_ASR_OK;
    end else begin
      // a start during a search is ignored until the search ends
      case (asr_fsm_reg)
        R_IDLE: begin
          if (asr_start) begin
            if (asr_vwin_error) begin
              asr_state_reg <= `VSIC_ASR_VWIN;
            end else if ((asr_mask_reg & rate_set) == 7'h00) begin
              asr_state_reg <= `VSIC_ASR_DISABLED;
            end else begin
              asr_state_reg <= `VSIC_ASR_BUSY;
              asr_fsm_reg <= R_SEARCH;
            end
          end
        end
        R_SEARCH: begin
          if (asr_found_valid) begin
            asr_fsm_reg <= R_IDLE;
            if (asr_found_ok && asr_mask_ext[asr_found_std])
              asr_state_reg <= `VSIC_ASR_OK;
            else
              asr_state_reg <= `VSIC_ASR_FAILED;
          end
        end
        default: asr_fsm_reg <= R_IDLE;
      endcase
    end
  end

  // unmapped indices read zero and raise pslverr
  always @* begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    case (idx)
      `VSIC_IDX_STD_SEL: rdata[11:0] = std_sel_reg;
      `VSIC_IDX_INSEL: rdata[11:0] = insel_reg;
      `VSIC_IDX_START_POS: rdata[11:0] = start_pos_reg;
      `VSIC_IDX_LC_DELAY: rdata[11:0] = lc_delay_reg;
      `VSIC_IDX_HELPER_DLY: rdata[11:0] = helper_dly_reg;
      `VSIC_IDX_ASR_MASK: rdata[6:0] = asr_mask_reg;
      `VSIC_IDX_ASR_STATE: rdata[3:0] = asr_state_reg;
      `VSIC_IDX_IRQ_STAT: rdata[2:0] = irq_stat_reg;
      `VSIC_IDX_IRQ_MASK: rdata[2:0] = irq_mask_reg;
      default: hit = 1'b0;
    endcase
  end

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = (psel & penable & ~pwrite) ? rdata : 32'h0000_0000;
  // level output; drops as soon as the status or the mask bit clears
  assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule

// *** testbench/vsic_asserts.sv ***
`timescale 1ns/1ps
module vsic_asserts (
  input wire core_clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [1:0] input_mode,
  input wire comb_enable,
  input wire separate_luma_chroma_input,
  input wire [2:0] active_standard,
  input wire [1:0] if_compensation,
  input wire [1:0] horizontal_lock_speed,
  input wire [5:0] luma_chroma_delay,
  input wire standard_reload,
  input wire [2:0] setup_phase,
  input wire setup_busy
);
  wire sw = psel && penable && pwrite && paddr[11:2] == 10'h020;
  wire iw = psel && penable && pwrite && paddr[11:2] == 10'h021;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  property p_mode;
    comb_enable == (input_mode == 2'b01) && separate_luma_chroma_input == (input_mode == 2'b10);
  endproperty
  a_mode: assert property (p_mode) else $error("mode outputs disagree");
  property p_full;
    sw && pwdata[10:7] == 4'h0 |=> setup_phase == 3'd1 ##4 setup_phase == 3'd2
      ##4 setup_phase == 3'd3 ##4 setup_phase == 3'd4 ##4 !setup_busy;
  endproperty
  a_full: assert property (p_full) else $error("full setup order wrong");
  property p_comb;
    sw && pwdata[10] |=> (setup_phase == 3'd4 && setup_busy)[*4] ##1 setup_phase == 3'd0;
  endproperty
  a_comb: assert property (p_comb) else $error("comb-only setup wrong");
  property p_insel;
    iw |=> setup_busy && setup_phase != 3'd0;
  endproperty
  a_insel: assert property (p_insel) else $error("input write did not start setup");
  property p_ifc;
    if_compensation == 2'b11 |-> active_standard == 3'h2;
  endproperty
  a_ifc: assert property (p_ifc) else $error("steep compensation outside secam");
  property p_hl;
    horizontal_lock_speed != 2'b00;
  endproperty
  a_hl: assert property (p_hl) else $error("lock speed shows no-change code");
  property p_luma_chroma_delay;
    $changed(luma_chroma_delay) |-> $past(sw) && $signed(luma_chroma_delay) <= 1
      && $signed(luma_chroma_delay) >= -7;
  endproperty
  a_luma_chroma_delay: assert property (p_luma_chroma_delay) else $error("luma delay moved wrongly");
  property p_reload;
    sw |=> standard_reload ##1 !standard_reload;
  endproperty
  a_reload: assert property (p_reload) else $error("reload pulse wrong");
  c_full: cover property (sw && pwdata[10:7] == 4'h0);
  c_ins: cover property (iw);
  c_ifc: cover property (if_compensation == 2'b11);
endmodule
bind vsic_video_standard_input_control vsic_asserts u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .input_mode(input_mode), .comb_enable(comb_enable),
  .separate_luma_chroma_input(separate_luma_chroma_input), .active_standard(active_standard),
  .if_compensation(if_compensation), .horizontal_lock_speed(horizontal_lock_speed),
  .luma_chroma_delay(luma_chroma_delay), .standard_reload(standard_reload),
  .setup_phase(setup_phase), .setup_busy(setup_busy)
);

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  localparam [11:0] STD = 12'h020, INS = 12'h021, SP = 12'h022, LC = 12'h023, HD = 12'h029;
  localparam [11:0] AM = 12'h148, AS = 12'h14e, IS = 12'h150, IM = 12'h151;
  reg core_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg scaler_mode_written = 1'b0, asr_start = 1'b0, asr_vwin_error = 1'b0;
  reg asr_field_60hz = 1'b0, asr_found_valid = 1'b0, asr_found_ok = 1'b0;
  reg [2:0] asr_found_std = 3'h0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, irq, comb_enable, separate_luma_chroma_input, luma_notch_enable;
  wire secam_trap_mode, luma_smoothing_enable, standard_reload, setup_busy;
  wire [1:0] input_mode, if_compensation, horizontal_lock_speed;
  wire [2:0] active_standard, setup_phase;
  wire [11:0] active_video_start, helper_line_delay;
  wire [5:0] luma_chroma_delay;
  wire [4:0] mode_seen = {luma_notch_enable, comb_enable, separate_luma_chroma_input, input_mode};
  integer fail_count = 0, n_compared = 0, seed = 52498, i, k;
  reg [31:0] rd;
  reg err, vw, f6, ok;
  reg [11:0] v, h, a;
  reg [5:0] dv;
  reg [3:0] op;
  reg [2:0] s;
  reg [1:0] hl;
  reg [7:0] m;
  reg [4:0] em;
  vsic_video_standard_input_control dut (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .scaler_mode_written(scaler_mode_written),
    .asr_start(asr_start), .asr_vwin_error(asr_vwin_error), .asr_field_60hz(asr_field_60hz),
    .asr_found_valid(asr_found_valid), .asr_found_ok(asr_found_ok),
    .asr_found_std(asr_found_std), .active_standard(active_standard),
    .input_mode(input_mode), .comb_enable(comb_enable),
    .separate_luma_chroma_input(separate_luma_chroma_input),
    .luma_notch_enable(luma_notch_enable), .if_compensation(if_compensation),
    .secam_trap_mode(secam_trap_mode), .luma_smoothing_enable(luma_smoothing_enable),
    .horizontal_lock_speed(horizontal_lock_speed), .active_video_start(active_video_start),
    .luma_chroma_delay(luma_chroma_delay), .helper_line_delay(helper_line_delay),
    .standard_reload(standard_reload), .setup_phase(setup_phase), .setup_busy(setup_busy)
  );
  always #4 core_clk = ~core_clk;
  // setup length in cycles; comb phase always runs
  function [31:0] nph(input [3:0] o);
    nph = o[3] ? 4 : 4 * (4 - o[0] - o[1] - o[2]);
  endfunction
  function [5:0] cl(input [5:0] d);
    cl = ($signed(d) > 1) ? 6'h01 : ($signed(d) < -7) ? 6'h39 : d;
  endfunction
  function [3:0] st0(input [7:0] mk, input x, input f);
    st0 = x ? 4'h1 : ((mk[6:0] & (f ? 7'h5a : 7'h25)) == 7'h0) ? 4'h2 : 4'h4;
  endfunction
  task chk(input [8*10:1] nm, input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task bus(input w, input [11:0] ix, input [31:0] d);
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {ix[9:0], 2'b00};
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rc(input [8*10:1] nm, input [11:0] ix, input [31:0] e);
    begin
      bus(1'b0, ix, 32'h0);
      chk(nm, rd, e);
    end
  endtask
  task idle;
    begin
      k = 0;
      @(posedge core_clk);
      while (setup_busy === 1'b1) begin
        k = k + 1;
        @(posedge core_clk);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    #100000;
    fail_count = fail_count + 1;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    chk("hlock rst", horizontal_lock_speed, 3);
    rc("insel rst", INS, 32'h644);
    rc("start rst", SP, 0);
    rc("luma_chroma_delay rst", LC, 0);
    rc("help rst", HD, 0);
    rc("mask rst", AM, 0);
    bus(1'b1, AS, 32'hfff);
    rc("state ro", AS, 0);
    bus(1'b0, 12'h3ff, 32'h0);
    chk("slverr", err, 1);
    chk("slv rdata", rd, 0);
    chk("pready", pready, 1);
    $display("test 1 ends");
    hl = 2'd3;
    for (i = 0; i < 8; i = i + 1) begin
      op = (i == 0) ? 4'h0 : (i < 5) ? 4'h1 << (i - 1) : $random(seed);
      s = (i == 0) ? 3'h2 : (i == 1) ? 3'h0 : $random(seed);
      v = $random(seed);
      v[11] = 1'b0;
      if (i < 2) v[4:3] = 2'b11;
      bus(1'b1, STD, {21'h0, op, i[1:0], 2'b00, s});
      idle;
      chk("std cycles", k, nph(op));
      rc("std done", STD, {20'h0, 1'b1, op, i[1:0], 2'b00, s});
      chk("standard", active_standard, s);
      em = {i[1:0] == 2'b00, i[1:0] == 2'b01, i[1:0] == 2'b10, i[1:0]};
      chk("mode", mode_seen, em);
      bus(1'b1, INS, {20'h0, v});
      idle;
      chk("ins cycles", k, nph(op));
      rc("ins done", INS, {20'h0, 1'b1, v[10:0]});
      rc("std kept", STD, {20'h0, 1'b1, op, i[1:0], 2'b00, s});
      if (v[10:9] != 2'b00) hl = v[10:9];
      chk("ifc", if_compensation, (v[4:3] == 2'b11 && s != 3'h2) ? 2'b00 : v[4:3]);
      chk("trap", {secam_trap_mode, luma_smoothing_enable}, {v[7], v[8]});
      chk("hlock", horizontal_lock_speed, hl);
    end
    $display("test 2 ends");
    a = 12'h000;
    for (i = 0; i < 6; i = i + 1) begin
      dv = (i == 0) ? 6'h01 : (i == 1) ? 6'h02 : (i == 2) ? 6'h39 : (i == 3) ? 6'h38 : $random(seed);
      h = $random(seed);
      v = ~a ^ ($random(seed) & 12'h0f0);
      bus(1'b1, LC, {20'h0, dv, 6'h3f});
      rc("luma_chroma_delay reg", LC, {20'h0, cl(dv), 6'h00});
      bus(1'b1, HD, {20'h0, h});
      bus(1'b1, SP, {20'h0, v});
      chk("start old", active_video_start, a);
      if (i == 5) begin
        @(posedge core_clk);
        scaler_mode_written <= 1'b1;
        @(posedge core_clk);
        scaler_mode_written <= 1'b0;
        @(posedge core_clk);
      end else begin
        bus(1'b1, STD, {27'h0, i[0], 4'h0} | 32'h400);
        idle;
        chk("luma_chroma_delay out", luma_chroma_delay, cl(dv));
        chk("helper", helper_line_delay, i[0] ? h : 12'h0);
      end
      @(posedge core_clk);
      a = v;
      chk("start new", active_video_start, a);
    end
    $display("test 3 ends");
    for (i = 0; i < 12; i = i + 1) begin
      m = (i == 0) ? 8'h00 : (i == 2) ? 8'h7f : ($random(seed) & 8'h7f);
      vw = (i == 1);
      f6 = $random(seed);
      ok = $random(seed);
      s = $random(seed);
      bus(1'b1, AM, {24'h0, m});
      rc("mask", AM, {24'h0, m});
      @(posedge core_clk);
      asr_vwin_error <= vw;
      asr_field_60hz <= f6;
      asr_start <= 1'b1;
      @(posedge core_clk);
      asr_start <= 1'b0;
      rc("asr start", AS, st0(m, vw, f6));
      if (st0(m, vw, f6) == 4'h4) begin
        asr_found_ok <= ok;
        asr_found_std <= s;
        asr_found_valid <= 1'b1;
        @(posedge core_clk);
        asr_found_valid <= 1'b0;
        rc("asr end", AS, (ok && m[s]) ? 0 : 8);
      end
    end
    $display("test 4 ends");
    // status is sticky, so all three events are pending here
    bus(1'b1, IM, 0);
    @(posedge core_clk);
    chk("irq off", irq, 0);
    rc("irq stat", IS, 7);
    bus(1'b1, IM, 2);
    @(posedge core_clk);
    chk("irq on", irq, 1);
    bus(1'b1, IS, 2);
    @(posedge core_clk);
    chk("irq clr", irq, 0);
    rc("irq stat2", IS, 5);
    $display("test 5 ends");
    tally_and_finish;
  end
endmodule
